// [src/selftest_sensor_ctrl.sv]
// Self-test and sensing control register bank with a parity-error injector.
// Assumes one AHB-Lite master on clk_sys and a serializer that takes one error per pulse.
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module selftest_sensor_ctrl
    import selftest_sensor_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // AHB-Lite slave port.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Self-test controls toward the serializer core.
    output logic parity_error_pulse,
    output logic selftest_mode,
    output logic far_selftest_enable,
    output logic [1:0] selftest_clock_select,
    // Sensing controls toward the analog sensors.
    output logic [6:0] voltage_gain_divisor,
    output logic sensor_gain_enable,
    output logic temp_sensor_on,
    output logic volt_sensor_on,
    output logic [1:0] pin_sense_enable
);
    import selftest_sensor_pkg::*;

    // Register state.
    logic trigger_q, trigger_d;
    logic [6:0] inj_count_q, inj_count_d;
    logic [3:0] inj_enable_q, inj_enable_d;
    logic local_en_q, local_en_d;
    logic [1:0] clk_sel_q, clk_sel_d;
    logic far_en_q, far_en_d;
    logic [6:0] gain_div_q, gain_div_d;
    logic [7:0] rsvd16_q, rsvd16_d;
    logic [3:0] ctrl0_up_q, ctrl0_up_d;
    logic [1:0] sens_en_q, sens_en_d;
    logic [1:0] pin_sel_q, pin_sel_d;
    logic gain_en_q, gain_en_d;
    logic [6:0] ctrl1_lo_q, ctrl1_lo_d;
    // Bus data-phase state.
    logic wr_pend_q, wr_pend_d;
    logic [7:0] wr_idx_q, wr_idx_d;
    logic [31:0] rdata_q, rdata_d;
    // Injector state.
    inject_state_t inj_state_q, inj_state_d;
    logic [6:0] remaining_q, remaining_d;
    logic pulse_q, pulse_d;
    logic mode_q, mode_d;

    logic addr_phase;
    logic [7:0] addr_idx;
    logic trigger_write;
    logic mode_entry;
    logic inject_done;
    logic run_start;

    // Address phase is accepted only for a selected NONSEQ or SEQ transfer (htrans[1] set) with hready high; hsize is not checked.
    assign addr_phase = hsel && hready && htrans[1];
    assign addr_idx = haddr[9:2];

    // Read mux over the next values, so a read right behind a write to the same
    // register already sees the written data; unmapped and upper bits read as zero.
    function automatic logic [31:0] read_reg(input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            IDX_PARITY_INJ: v = {trigger_d, inj_count_d};
            IDX_SELFTEST_CTRL: v = {inj_enable_d, local_en_d, clk_sel_d, far_en_d};
            IDX_VGAIN: v = {1'b0, gain_div_d};
            IDX_RSVD_16: v = rsvd16_d;
            IDX_SENSE_CTRL0: v = {ctrl0_up_d, sens_en_d, pin_sel_d};
            IDX_SENSE_CTRL1: v = {gain_en_d, ctrl1_lo_d};
            default: v = 8'h00;
        endcase
        return {24'h000000, v};
    endfunction

    // Bus phase tracking: a write lands one cycle after its address phase.
    always_comb
    begin
        wr_pend_d = addr_phase && hwrite;
        wr_idx_d = addr_phase ? addr_idx : wr_idx_q;
        rdata_d = (addr_phase && !hwrite) ? read_reg(addr_idx) : 32'h00000000;
    end

    assign trigger_write = wr_pend_q && (wr_idx_q == IDX_PARITY_INJ) && hwdata[TRIGGER_BIT];
    assign mode_entry = local_en_q && !mode_q;
    assign inject_done = (inj_state_q == INJ_RUN) && (remaining_q <= 7'h01);
    // A trigger that will launch a run stays set until the run has finished.
    assign run_start = trigger_q && inj_enable_q != 4'h0 && inj_count_q != 7'h00;

    // Register writes; the trigger set by software or entry outranks its own clear.
    always_comb
    begin
        trigger_d = trigger_q;
        inj_count_d = inj_count_q;
        inj_enable_d = inj_enable_q;
        local_en_d = local_en_q;
        clk_sel_d = clk_sel_q;
        far_en_d = far_en_q;
        gain_div_d = gain_div_q;
        rsvd16_d = rsvd16_q;
        ctrl0_up_d = ctrl0_up_q;
        sens_en_d = sens_en_q;
        pin_sel_d = pin_sel_q;
        gain_en_d = gain_en_q;
        ctrl1_lo_d = ctrl1_lo_q;
        if (inject_done || (inj_state_q == INJ_IDLE && trigger_q && !run_start))
        begin
            trigger_d = 1'b0;
        end
        if (wr_pend_q)
        begin
            unique case (wr_idx_q)
                IDX_PARITY_INJ: inj_count_d = hwdata[6:0];
                IDX_SELFTEST_CTRL:
                begin
                    inj_enable_d = hwdata[7:4];
                    local_en_d = hwdata[LOCAL_EN_BIT];
                    clk_sel_d = hwdata[2:1];
                    far_en_d = hwdata[FAR_EN_BIT];
                end
                IDX_VGAIN: gain_div_d = hwdata[6:0];
                IDX_RSVD_16: rsvd16_d = hwdata[7:0];
                IDX_SENSE_CTRL0:
                begin
                    ctrl0_up_d = hwdata[7:4];
                    sens_en_d = hwdata[3:2];
                    pin_sel_d = hwdata[1:0];
                end
                IDX_SENSE_CTRL1:
                begin
                    gain_en_d = hwdata[GAIN_EN_BIT];
                    ctrl1_lo_d = hwdata[6:0];
                end
                default: trigger_d = trigger_d;
            endcase
        end
        if (trigger_write || (mode_entry && inj_enable_q != 4'h0))
        begin
            trigger_d = 1'b1;
        end
    end

    // Injector: one pulse per cycle until the loaded count is spent.
    // A zero count or a zero enable field lets the trigger drop without pulses.
    always_comb
    begin
        inj_state_d = inj_state_q;
        remaining_d = remaining_q;
        pulse_d = 1'b0;
        mode_d = local_en_q;
        unique case (inj_state_q)
            INJ_IDLE:
            begin
                if (trigger_q && inj_enable_q != 4'h0 && inj_count_q != 7'h00)
                begin
                    inj_state_d = INJ_RUN;
                    remaining_d = inj_count_q;
                end
            end
            INJ_RUN:
            begin
                pulse_d = 1'b1;
                remaining_d = remaining_q - 7'h01;
                if (remaining_q <= 7'h01)
                begin
                    inj_state_d = INJ_IDLE;
                end
            end
        endcase
    end

    // All state registers.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            trigger_q <= 1'b0;
            inj_count_q <= RST_INJECT_COUNT;
            inj_enable_q <= RST_INJECT_ENABLE;
            local_en_q <= 1'b0;
            clk_sel_q <= RST_CLOCK_SELECT;
            far_en_q <= 1'b0;
            gain_div_q <= RST_GAIN_DIVISOR;
            rsvd16_q <= RST_RSVD_16;
            ctrl0_up_q <= RST_CTRL0_UPPER;
            sens_en_q <= RST_SENSOR_ENABLE;
            pin_sel_q <= RST_PIN_SELECT;
            gain_en_q <= RST_GAIN_ENABLE;
            ctrl1_lo_q <= RST_CTRL1_LOWER;
            wr_pend_q <= 1'b0;
            wr_idx_q <= 8'h00;
            rdata_q <= 32'h00000000;
            inj_state_q <= INJ_IDLE;
            remaining_q <= 7'h00;
            pulse_q <= 1'b0;
            mode_q <= 1'b0;
        end
        else
        begin
            trigger_q <= trigger_d;
            inj_count_q <= inj_count_d;
            inj_enable_q <= inj_enable_d;
            local_en_q <= local_en_d;
            clk_sel_q <= clk_sel_d;
            far_en_q <= far_en_d;
            gain_div_q <= gain_div_d;
            rsvd16_q <= rsvd16_d;
            ctrl0_up_q <= ctrl0_up_d;
            sens_en_q <= sens_en_d;
            pin_sel_q <= pin_sel_d;
            gain_en_q <= gain_en_d;
            ctrl1_lo_q <= ctrl1_lo_d;
            wr_pend_q <= wr_pend_d;
            wr_idx_q <= wr_idx_d;
            rdata_q <= rdata_d;
            inj_state_q <= inj_state_d;
            remaining_q <= remaining_d;
            pulse_q <= pulse_d;
            mode_q <= mode_d;
        end
    end

    // Outputs are flops except hreadyout and hresp, which are constants; the bank never waits and never errors.
    assign hrdata = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign parity_error_pulse = pulse_q;
    assign selftest_mode = mode_q;
    assign far_selftest_enable = far_en_q;
    assign selftest_clock_select = clk_sel_q;
    assign voltage_gain_divisor = gain_div_q;
    assign sensor_gain_enable = gain_en_q;
    assign temp_sensor_on = sens_en_q[1];
    assign volt_sensor_on = sens_en_q[0];
    assign pin_sense_enable = pin_sel_q;

    // Pulses appear only after a trigger, so nothing fires outside self-test unprompted.
    sequence run_start_s;
        (inj_state_q == INJ_IDLE) && trigger_q && inj_enable_q != 4'h0 && inj_count_q == 7'h03;
    endsequence
    sequence three_pulses_s;
        ##2 pulse_q [*3] ##1 !pulse_q;
    endsequence
    inject_count_a: assert property (@(posedge clk_sys) disable iff (reset)
        run_start_s |-> three_pulses_s)
        else $error("Injector did not emit the programmed count.");
    pulse_cause_a: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(pulse_q) |-> $past(inj_state_q, 1) == INJ_RUN && $past(trigger_q, 2))
        else $error("Parity pulse without a trigger.");
    entry_trigger_a: assert property (@(posedge clk_sys) disable iff (reset)
        (mode_entry && inj_enable_q != 4'h0) |=> trigger_q)
        else $error("Self-test entry did not start injection.");
    enable_block_a: assert property (@(posedge clk_sys) disable iff (reset)
        (inj_state_q == INJ_IDLE && inj_enable_q == 4'h0) |-> ##2 !pulse_q)
        else $error("Injection ran with the enable field at zero.");
    trigger_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
        (inject_done && !trigger_write && !mode_entry) |=> !trigger_q)
        else $error("Trigger bit did not clear after injection.");
    run_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
        (inj_state_q == INJ_RUN && !inject_done) |=> trigger_q)
        else $error("Trigger bit dropped before the run ended.");
    count_write_a: assert property (@(posedge clk_sys) disable iff (reset)
        (wr_pend_q && wr_idx_q == IDX_PARITY_INJ) |=> inj_count_q == $past(hwdata[6:0]))
        else $error("Count field did not take the written value.");
    mode_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(local_en_q) |=> selftest_mode)
        else $error("Self-test mode did not follow the local enable.");
    ctrl_write_a: assert property (@(posedge clk_sys) disable iff (reset)
        (wr_pend_q && wr_idx_q == IDX_SELFTEST_CTRL) |=>
            selftest_clock_select == $past(hwdata[2:1]) && far_selftest_enable == $past(hwdata[0]))
        else $error("Self-test control write lost.");
    sense_write_a: assert property (@(posedge clk_sys) disable iff (reset)
        (wr_pend_q && wr_idx_q == IDX_SENSE_CTRL0) |=>
            pin_sense_enable == $past(hwdata[1:0]) && temp_sensor_on == $past(hwdata[3]))
        else $error("Sensing control write lost.");
    gain_write_a: assert property (@(posedge clk_sys) disable iff (reset)
        (wr_pend_q && wr_idx_q == IDX_VGAIN) |=> voltage_gain_divisor == $past(hwdata[6:0]))
        else $error("Gain divisor write lost.");
    gain_en_write_a: assert property (@(posedge clk_sys) disable iff (reset)
        (wr_pend_q && wr_idx_q == IDX_SENSE_CTRL1) |=> sensor_gain_enable == $past(hwdata[7]))
        else $error("Gain enable write lost.");
endmodule

// [inc/selftest_sensor_pkg.sv]
// Constants for the self-test and sensing control bank.
// Assumes a 200 MHz system clock and an AHB-Lite register port.
package selftest_sensor_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_PARITY_INJ = 8'h13;
    localparam logic [7:0] IDX_SELFTEST_CTRL = 8'h14;
    localparam logic [7:0] IDX_VGAIN = 8'h15;
    localparam logic [7:0] IDX_RSVD_16 = 8'h16;
    localparam logic [7:0] IDX_SENSE_CTRL0 = 8'h17;
    localparam logic [7:0] IDX_SENSE_CTRL1 = 8'h18;
    // Field positions.
    localparam int TRIGGER_BIT = 7;
    localparam int LOCAL_EN_BIT = 3;
    localparam int FAR_EN_BIT = 0;
    localparam int GAIN_EN_BIT = 7;
    // Reset values.
    localparam logic [6:0] RST_INJECT_COUNT = 7'h00;
    localparam logic [3:0] RST_INJECT_ENABLE = 4'h0;
    localparam logic [1:0] RST_CLOCK_SELECT = 2'h0;
    localparam logic [6:0] RST_GAIN_DIVISOR = 7'h20;
    localparam logic [7:0] RST_RSVD_16 = 8'h18;
    localparam logic [3:0] RST_CTRL0_UPPER = 4'h3;
    localparam logic [1:0] RST_SENSOR_ENABLE = 2'h3;
    localparam logic [1:0] RST_PIN_SELECT = 2'h0;
    localparam logic RST_GAIN_ENABLE = 1'b1;
    localparam logic [6:0] RST_CTRL1_LOWER = 7'h00;
    // Gain numerator: gain = GAIN_NUMERATOR / divisor.
    localparam logic [7:0] GAIN_NUMERATOR = 8'h80;
    // Self-test clock source encodings.
    localparam logic [1:0] CLK_SRC_SYSTEM = 2'h0;
    localparam logic [1:0] CLK_SRC_50M = 2'h1;
    localparam logic [1:0] CLK_SRC_25M = 2'h2;
    // Injector states.
    typedef enum logic [1:0] {
        INJ_IDLE = 2'b01,
        INJ_RUN = 2'b10
    } inject_state_t;
endpackage

// [verif/test_selftest_sensor_ctrl.sv]
// Self-checking bench for the self-test and sensing control bank.
// Assumes the design is the only AHB-Lite slave, so its hreadyout is the bus hready.
`timescale 1ns/1ps
module test_selftest_sensor_ctrl;
    import selftest_sensor_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic parity_error_pulse;
    logic selftest_mode;
    logic far_selftest_enable;
    logic [1:0] selftest_clock_select;
    logic [6:0] voltage_gain_divisor;
    logic sensor_gain_enable;
    logic temp_sensor_on;
    logic volt_sensor_on;
    logic [1:0] pin_sense_enable;
    int error_cnt = 0;
    int total_checks = 0;
    int cycle_cnt = 0;
    logic [7:0] rst_tab [6] = '{8'h00, 8'h00, 8'h20, 8'h18, 8'h3c, 8'h80};

    // The one slave's hreadyout loops back as the bus hready.
    selftest_sensor_ctrl i_dut (
        .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .parity_error_pulse(parity_error_pulse), .selftest_mode(selftest_mode),
        .far_selftest_enable(far_selftest_enable),
        .selftest_clock_select(selftest_clock_select),
        .voltage_gain_divisor(voltage_gain_divisor), .sensor_gain_enable(sensor_gain_enable),
        .temp_sensor_on(temp_sensor_on), .volt_sensor_on(volt_sensor_on),
        .pin_sense_enable(pin_sense_enable)
    );

    // A 200 MHz clock.
    always #2.5 clk_sys = ~clk_sys;

    // The run takes under two thousand cycles; a hung handshake ends it here.
    always @(posedge clk_sys)
    begin
        cycle_cnt <= cycle_cnt + 1;
        if (cycle_cnt == 20000)
        begin
            error_cnt++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk_port(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD port t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Address phase is held until hready, then the data phase until hready again.
    task automatic bus_cycle(input logic [7:0] idx, input logic wr, input logic [7:0] d,
                             output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        haddr <= {22'h0, idx, 2'b00};
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        rd = hrdata;
    endtask

    task automatic chk_reg(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] rd;
        bus_cycle(idx, 1'b0, 8'h00, rd);
        total_checks++;
        if (rd !== {24'h0, exp})
        begin
            error_cnt++;
            $display("BAD reg %h t=%0t got=%h exp=%h", idx, $time, rd, exp);
        end
    endtask

    // Writes a register, then reads it back expecting the value written.
    task automatic wr_rd(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        bus_cycle(idx, 1'b1, d, rd);
        chk_reg(idx, d);
    endtask

    // Forced errors need a nonzero enable field and either the trigger or self-test entry.
    function automatic int exp_pulses(input logic [3:0] field, input logic [6:0] cnt,
                                      input logic go);
        return (field != 4'h0 && go) ? int'(cnt) : 0;
    endfunction

    task automatic run_inject(input logic [3:0] field, input logic [6:0] cnt,
                              input logic trig, input logic local_en);
        int n;
        logic [31:0] rd;
        n = 0;
        bus_cycle(IDX_SELFTEST_CTRL, 1'b1, {field, 4'h0}, rd);
        bus_cycle(IDX_PARITY_INJ, 1'b1, {1'b0, cnt}, rd);
        if (trig)
            bus_cycle(IDX_PARITY_INJ, 1'b1, {1'b1, cnt}, rd);
        if (local_en)
            bus_cycle(IDX_SELFTEST_CTRL, 1'b1, {field, 4'h8}, rd);
        repeat (140)
        begin
            @(posedge clk_sys);
            if (parity_error_pulse === 1'b1)
                n++;
        end
        chk_port(n, exp_pulses(field, cnt, trig | local_en));
        chk_reg(IDX_PARITY_INJ, {1'b0, cnt});
        chk_port(selftest_mode, local_en);
        $display("test inject field %h count %0d done", field, cnt);
    endtask

    // Main sequence: reset values, random read-write with corner codes, then injection.
    initial
    begin
        logic [7:0] d;
        logic [7:0] v;
        logic [1:0] code;
        logic [31:0] rd;
        d = 8'($urandom(32'h5eb8d475));
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        chk_port({parity_error_pulse, selftest_mode, far_selftest_enable,
                  selftest_clock_select, voltage_gain_divisor, sensor_gain_enable,
                  temp_sensor_on, volt_sensor_on, pin_sense_enable},
                 {3'b000, 2'b00, 7'h20, 3'b111, 2'b00});
        for (int k = 0; k < 6; k++)
            chk_reg(8'h13 + 8'(k), rst_tab[k]);
        chk_reg(8'h12, 8'h00);
        chk_reg(8'h19, 8'h00);
        chk_port({hreadyout, hresp}, 32'h2);
        $display("test reset done");
        for (int i = 0; i < 24; i++)
        begin
            d = 8'($urandom());
            code = 2'(i);
            v = {d[7:4], 1'b0, code, d[0]};
            wr_rd(IDX_SELFTEST_CTRL, v);
            chk_port({selftest_clock_select, far_selftest_enable}, {code, d[0]});
            v = (i < 3) ? (8'h40 >> i) : {1'b0, d[6:0]};
            wr_rd(IDX_VGAIN, v);
            chk_port(voltage_gain_divisor, v[6:0]);
            wr_rd(IDX_RSVD_16, d);
            v = {d[7:4], (i[2] ? 2'b11 : 2'b00), code};
            wr_rd(IDX_SENSE_CTRL0, v);
            chk_port({temp_sensor_on, volt_sensor_on, pin_sense_enable}, v[3:0]);
            wr_rd(IDX_SENSE_CTRL1, d);
            chk_port(sensor_gain_enable, d[7]);
            wr_rd(IDX_PARITY_INJ, {1'b0, d[6:0]});
            bus_cycle(8'h19, 1'b1, d, rd);
            chk_reg(8'h19, 8'h00);
        end
        $display("test random registers done");
        run_inject(4'h1, 7'd1, 1'b1, 1'b0);
        run_inject(4'h4, 7'd3, 1'b1, 1'b0);
        run_inject(4'hf, 7'h7f, 1'b1, 1'b0);
        run_inject(4'h0, 7'd5, 1'b1, 1'b0);
        run_inject(4'h3, 7'd0, 1'b1, 1'b0);
        run_inject(4'h2, 7'(d), 1'b0, 1'b1);
        run_inject(4'h0, 7'd3, 1'b0, 1'b1);
        run_inject(4'h5, 7'd9, 1'b0, 1'b0);
        close_out();
    end
endmodule
